// ==== gpp_top.sv ====
// Per-port configuration, pin steering and combined interrupt for the general purpose ports.
`timescale 1ns/1ps
`include "gpp_params.svh"
module gpp_top #(
  parameter int unsigned DEBOUNCE_CYCLES =
    `GPP_DEBOUNCE_TIME_NS / `GPP_CLK_PERIOD_NS + 1
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       cfg_mode,
  input  wire logic                       cfg_wr,
  input  wire logic                       cfg_rd,
  input  wire logic [`GPP_IDX_W-1:0]      cfg_index,
  input  wire gpp_pkg::gpp_cfg_t          cfg_wdata,
  output gpp_pkg::gpp_cfg_t               cfg_rdata,
  input  wire logic                       data_wr,
  input  wire logic                       data_rd,
  input  wire gpp_pkg::gpp_vec_t          data_wdata,
  output gpp_pkg::gpp_vec_t               data_rdata,
  input  wire gpp_pkg::gpp_vec_t          debounce_en,
  input  wire gpp_pkg::gpp_chan_t         combined_irq_channel_select,
  input  wire gpp_pkg::gpp_vec_t          general_purpose_port_in,
  output gpp_pkg::gpp_vec_t               general_purpose_port_out,
  output gpp_pkg::gpp_vec_t               general_purpose_port_oe,
  input  wire gpp_pkg::gpp_vec_t          alternate_function_out,
  output gpp_pkg::gpp_vec_t               alternate_function_in,
  output logic                            combined_port_irq,
  output gpp_pkg::gpp_chan_t              combined_irq_chan,
  output logic                            direct_irq_port_a,
  output gpp_pkg::gpp_chan_t              direct_irq_port_a_chan,
  output logic                            direct_irq_port_b,
  output gpp_pkg::gpp_chan_t              direct_irq_port_b_chan
);
  import gpp_pkg::*;

  localparam int N = `GPP_NUM_PORTS;
  localparam gpp_vec_t ALT_IN_TYPE = `GPP_ALT_INPUT_MASK;

  gpp_cfg_t port_cfg [N];
  gpp_vec_t data_reg;
  gpp_vec_t pin_meta;
  gpp_vec_t pin_sync;
  gpp_vec_t filtered;

  wire gpp_vec_t dir_in;
  wire gpp_vec_t invert;
  wire gpp_vec_t steer;
  wire gpp_vec_t alt_sel;
  wire gpp_vec_t use_alt_out;
  wire gpp_vec_t use_alt_in;
  wire gpp_vec_t in_value;
  wire gpp_vec_t drive_value;
  wire gpp_vec_t irq_source;
  wire gpp_vec_t read_value;
  wire gpp_vec_t next_data;
  wire logic     cfg_wr_ok;
  wire logic     next_irq;
  wire gpp_cfg_t sel_cfg;

  assign cfg_wr_ok = cfg_wr && cfg_mode;
  assign sel_cfg   = port_cfg[cfg_index];

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_port
      assign dir_in[g]  = port_cfg[g][`GPP_BIT_DIR_IN];
      assign invert[g]  = port_cfg[g][`GPP_BIT_INVERT];
      assign steer[g]   = port_cfg[g][`GPP_BIT_IRQ_STEER];
      assign alt_sel[g] = port_cfg[g][`GPP_BIT_ALT_SEL];

      assign use_alt_out[g] = alt_sel[g] && !ALT_IN_TYPE[g] && !dir_in[g];
      assign use_alt_in[g]  = alt_sel[g] && ALT_IN_TYPE[g] && dir_in[g];

      assign in_value[g]    = pin_sync[g] ^ invert[g];
      assign drive_value[g] = (use_alt_out[g] ? alternate_function_out[g] : data_reg[g])
                              ^ invert[g];

      assign irq_source[g]  = steer[g] && (dir_in[g] ? filtered[g] : drive_value[g]);

      // input reads pin, output reads register
      assign read_value[g]  = dir_in[g] ? in_value[g] : data_reg[g];
      assign next_data[g]   = dir_in[g] ? data_reg[g] : data_wdata[g];

      gpp_debounce #(
        .STABLE_CYCLES (DEBOUNCE_CYCLES)
      ) u_deb (
        .clk_sys (clk_sys),
        .rst     (rst),
        .raw     (in_value[g]),
        .bypass  (!debounce_en[g]),
        .clean   (filtered[g])
      );

      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          port_cfg[g] <= `GPP_CFG_RESET;
        else if (cfg_wr_ok && (cfg_index == `GPP_IDX_W'(g)))
          port_cfg[g] <= cfg_wdata;
      end
    end
  endgenerate

  assign next_irq = |irq_source;

  // The pin is never read directly; two flops guard against metastability.
  // input buffer always sampled
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= general_purpose_port_in;
      pin_sync <= pin_meta;
    end
  end

  // writes land only on output bits
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      data_reg <= `GPP_DATA_RESET;
    else if (data_wr)
      data_reg <= next_data;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      data_rdata <= '0;
    else if (data_rd)
      data_rdata <= read_value;
  end

  // reads return zero outside configuration mode
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cfg_rdata <= '0;
    else if (cfg_rd)
      cfg_rdata <= cfg_mode ? sel_cfg : '0;
  end

  // Pin drivers; the output enable follows direction alone.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      general_purpose_port_out <= '0;
      general_purpose_port_oe  <= '0;
      alternate_function_in    <= '0;
    end
    else
    begin
      general_purpose_port_out <= drive_value;
      general_purpose_port_oe  <= ~dir_in;
      alternate_function_in    <= use_alt_in & in_value;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      combined_port_irq <= 1'b0;
      combined_irq_chan <= '0;
    end
    else
    begin
      combined_port_irq <= next_irq;
      combined_irq_chan <= combined_irq_channel_select;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      direct_irq_port_a      <= 1'b0;
      direct_irq_port_b      <= 1'b0;
      direct_irq_port_a_chan <= '0;
      direct_irq_port_b_chan <= '0;
    end
    else
    begin
      direct_irq_port_a      <= alternate_function_in[`GPP_DIRECT_PORT_A];
      direct_irq_port_b      <= alternate_function_in[`GPP_DIRECT_PORT_B];
      direct_irq_port_a_chan <=
        port_cfg[`GPP_DIRECT_PORT_A][`GPP_CHAN_MSB:`GPP_CHAN_LSB];
      direct_irq_port_b_chan <=
        port_cfg[`GPP_DIRECT_PORT_B][`GPP_CHAN_MSB:`GPP_CHAN_LSB];
    end
  end
endmodule : gpp_top

// ==== gpp_params.svh ====
// Constants for the general purpose port configuration and steering block.
`ifndef GPP_PARAMS_SVH
`define GPP_PARAMS_SVH
`define GPP_NUM_PORTS        8
`define GPP_IDX_W            3
`define GPP_CFG_W            8
`define GPP_CFG_RESET        8'h01
`define GPP_BIT_DIR_IN       0
`define GPP_BIT_INVERT       1
`define GPP_BIT_IRQ_STEER    2
`define GPP_BIT_ALT_SEL      3
`define GPP_CHAN_LSB         4
`define GPP_CHAN_MSB         7
`define GPP_ALT_INPUT_MASK   8'h03
`define GPP_DIRECT_PORT_A    0
`define GPP_DIRECT_PORT_B    1
`define GPP_DATA_RESET       8'h00
`define GPP_CLK_PERIOD_NS    10
`define GPP_DEBOUNCE_TIME_NS 1000000
`define GPP_DEB_CNT_W        17
`endif

// ==== gpp_pkg.sv ====
// Types shared by the general purpose port block.
package gpp_pkg;
  typedef logic [7:0] gpp_cfg_t;
  typedef logic [7:0] gpp_vec_t;
  typedef logic [3:0] gpp_chan_t;
endpackage : gpp_pkg

// ==== gpp_debounce.sv ====
// Selectable pulse-rejecting filter for one steered input.
`timescale 1ns/1ps
`include "gpp_params.svh"
module gpp_debounce #(
  parameter int unsigned STABLE_CYCLES = 100001
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic raw,
  input  wire logic bypass,
  output logic      clean
);
  logic [`GPP_DEB_CNT_W-1:0] cnt;
  logic [`GPP_DEB_CNT_W-1:0] next_cnt;
  wire logic                 differs;
  wire logic                 expired;

  assign differs  = raw != clean;
  assign expired  = cnt == `GPP_DEB_CNT_W'(STABLE_CYCLES - 1);
  assign next_cnt = differs ? cnt + `GPP_DEB_CNT_W'(1) : '0;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt   <= '0;
      clean <= 1'b0;
    end
    else if (bypass || (differs && expired))
    begin
      cnt   <= '0;
      clean <= raw;
    end
    else
    begin
      cnt   <= next_cnt;
      clean <= clean;
    end
  end
endmodule : gpp_debounce

// ==== gpp_top_props.sv ====
// Port-level properties of the general purpose port block.
`timescale 1ns/1ps
`include "gpp_params.svh"
module gpp_top_props (
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic                  cfg_mode,
  input wire logic                  cfg_wr,
  input wire logic                  cfg_rd,
  input wire logic [`GPP_IDX_W-1:0] cfg_index,
  input wire gpp_pkg::gpp_cfg_t     cfg_wdata,
  input wire gpp_pkg::gpp_cfg_t     cfg_rdata,
  input wire gpp_pkg::gpp_vec_t     general_purpose_port_oe,
  input wire gpp_pkg::gpp_vec_t     alternate_function_in,
  input wire logic                  direct_irq_port_a,
  input wire gpp_pkg::gpp_chan_t    direct_irq_port_a_chan
);
  import gpp_pkg::*;
  logic wr_ok;
  assign wr_ok = cfg_wr && cfg_mode;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_closed_read:
  assert property (cfg_rd && !cfg_mode |=> cfg_rdata == 8'h00) else $error("closed read");
  a_dir_write:
  assert property (wr_ok |-> ##2 general_purpose_port_oe[$past(cfg_index, 2)]
    == !$past(cfg_wdata[0], 2)) else $error("oe after write");
  a_oe_cause:
  assert property ($changed(general_purpose_port_oe) |-> $past(wr_ok, 2)) else $error("oe moved");
  a_read_dir:
  assert property (cfg_rd && cfg_mode |=> cfg_rdata[0]
    == !general_purpose_port_oe[$past(cfg_index)]) else $error("read vs oe");
  a_rdata_hold:
  assert property (!cfg_rd |=> $stable(cfg_rdata)) else $error("rdata moved");
  a_direct_chan:
  assert property (cfg_rd && cfg_mode && cfg_index == 3'h0 |=>
    direct_irq_port_a_chan == cfg_rdata[7:4]) else $error("direct chan");
  a_alt_mask:
  assert property ((alternate_function_in & ~`GPP_ALT_INPUT_MASK) == 8'h00) else $error("alt bit");
  a_direct_src:
  assert property (direct_irq_port_a |-> $past(alternate_function_in[0])
    || $past(alternate_function_in[0], 2)) else $error("direct source");
endmodule : gpp_top_props
bind gpp_top gpp_top_props props_u (.clk_sys, .rst, .cfg_mode, .cfg_wr, .cfg_rd, .cfg_index,
  .cfg_wdata, .cfg_rdata, .general_purpose_port_oe, .alternate_function_in,
  .direct_irq_port_a, .direct_irq_port_a_chan);

// ==== gpp_pin_model.sv ====
// Pin wires: device drive where enabled, else the external source.
`timescale 1ns/1ps
module gpp_pin_model (
  input  wire gpp_pkg::gpp_vec_t oe,
  input  wire gpp_pkg::gpp_vec_t drv,
  input  wire gpp_pkg::gpp_vec_t ext,
  output gpp_pkg::gpp_vec_t      pin
);
  import gpp_pkg::*;
  // input always sensed
  // The wire level is fed back even while driven, so outputs loop into the input path.
  assign pin = (oe & drv) | (~oe & ext);
endmodule : gpp_pin_model

// ==== gpp_top_tb.sv ====
// Self-checking bench for the general purpose port block.
`timescale 1ns/1ps
`include "gpp_params.svh"
module gpp_top_tb;
  import gpp_pkg::*;
  localparam int DEB = 8;
  logic clk_sys = 1'h0, rst = 1'h1, cfg_mode = 1'h0, cfg_wr = 1'h0, cfg_rd = 1'h0;
  logic data_wr = 1'h0, data_rd = 1'h0, irq, da, db, pend = 1'h0;
  logic [2:0] cfg_index = 3'h0, p;
  logic [19:0] q[$], ent;
  logic [15:0] got;
  gpp_cfg_t cfg_wdata = 8'h00, cfg_rdata;
  gpp_vec_t data_wdata = 8'h00, debounce_en = 8'h00, ext = 8'h00, alt_o = 8'h00;
  gpp_vec_t data_rdata, pin, pout, poe, alt_i;
  gpp_chan_t sel = 4'h0, achan, bchan, cchan;
  int failures = 0, cmp_count = 0;
  always #5 clk_sys = ~clk_sys;
  gpp_pin_model pins_u (.oe(poe), .drv(pout), .ext, .pin);
  gpp_top #(.DEBOUNCE_CYCLES(DEB)) dut_u (.clk_sys, .rst, .cfg_mode, .cfg_wr, .cfg_rd,
    .cfg_index, .cfg_wdata, .cfg_rdata, .data_wr, .data_rd, .data_wdata, .data_rdata,
    .debounce_en, .combined_irq_channel_select(sel), .general_purpose_port_in(pin),
    .general_purpose_port_out(pout), .general_purpose_port_oe(poe),
    .alternate_function_out(alt_o), .alternate_function_in(alt_i), .combined_port_irq(irq),
    .combined_irq_chan(cchan), .direct_irq_port_a(da), .direct_irq_port_a_chan(achan),
    .direct_irq_port_b(db), .direct_irq_port_b_chan(bchan));
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  // Results are taken at the falling edge, clear of the edge that updates them.
  always @(negedge clk_sys)
  begin
    if (pend)
    begin
      ent = q.pop_front();
      p = ent[18:16];
      got = ent[19] ? {8'h00, cfg_rdata} : {2'h0, (p == 3'h0 ? achan : bchan), cchan, poe[p],
        poe[p] & pout[p], alt_i[p], irq, data_rdata[p], (p == 3'h0 ? da : db)};
      cmp_count++;
      if (got !== ent[15:0])
      begin
        failures++;
        $display("wrong value at %0t: got %h, expected %h", $time, got, ent[15:0]);
      end
    end
    pend = cfg_rd | data_rd;
  end
  task automatic cfg(input logic [2:0] i, input gpp_cfg_t d, input logic w);
    if (!w)
      q.push_back({1'h1, i, 8'h00, d});
    cfg_index <= i;
    cfg_wdata <= d;
    cfg_wr <= w;
    cfg_rd <= !w;
    @(posedge clk_sys);
    cfg_wr <= 1'h0;
    cfg_rd <= 1'h0;
    @(posedge clk_sys);
  endtask : cfg
  task automatic rd(input logic [2:0] i, input logic [13:0] e);
    q.push_back({1'h0, i, 2'h0, e});
    data_rd <= 1'h1;
    @(posedge clk_sys);
    data_rd <= 1'h0;
    @(posedge clk_sys);
  endtask : rd
  task automatic run(input logic [2:0] i, input logic [3:0] c);
    gpp_vec_t wd, ex, al;
    logic [3:0] hi;
    logic o, pv, ai;
    gpp_chan_t s;
    wd = 8'($urandom);
    ex = 8'($urandom);
    al = 8'($urandom);
    hi = 4'($urandom);
    s = 4'($urandom);
    cfg(i, {hi, c}, 1'h1);
    cfg(i, {hi, c}, 1'h0);
    data_wdata <= wd;
    data_wr <= 1'h1;
    ext <= ex;
    alt_o <= al;
    sel <= s;
    @(posedge clk_sys);
    data_wr <= 1'h0;
    o = (c[3] && i > 3'h1 ? al[i] : wd[i]) ^ c[1];
    pv = c[0] ? ex[i] ^ c[1] : o;
    ai = c[3] && i < 3'h2 && c[0] && pv;
    repeat (8) @(posedge clk_sys);
    rd(i, {(i < 3'h2 ? hi : 4'h0), s, !c[0], !c[0] && o, ai, c[2] && pv,
      (c[0] ? pv : wd[i]), ai});
    cfg(i, `GPP_CFG_RESET, 1'h1);
  endtask : run
  // Bound is over twenty times the expected run length.
  initial
  begin
    #200000;
    failures++;
    conclude();
  end
  initial
  begin
    void'($urandom(647));
    repeat (8) @(posedge clk_sys);
    rst <= 1'h0;
    sel <= 4'($urandom);
    @(posedge clk_sys);
    cfg(3'h2, 8'hFF, 1'h1);
    cfg(3'h2, 8'h00, 1'h0);
    cfg_mode <= 1'h1;
    for (int i = 0; i < 8; i++)
      cfg(i[2:0], `GPP_CFG_RESET, 1'h0);
    // Ports 0 and 1 have input-type alternates, port 2 an output-type one.
    for (int c = 0; c < 48; c++)
      run(3'(c / 16), c[3:0]);
    debounce_en <= 8'h08;
    cfg(3'h3, 8'h05, 1'h1);
    ext[3] <= 1'h0;
    repeat (12) @(posedge clk_sys);
    ext[3] <= 1'h1;
    repeat (5) @(posedge clk_sys);
    rd(3'h3, {4'h0, sel, 6'h02});
    ext[3] <= 1'h0;
    repeat (3) @(posedge clk_sys);
    rd(3'h3, {4'h0, sel, 6'h00});
    ext[3] <= 1'h1;
    repeat (16) @(posedge clk_sys);
    rd(3'h3, {4'h0, sel, 6'h06});
    repeat (3) @(posedge clk_sys);
    conclude();
  end
endmodule : gpp_top_tb
